/* rtl/cpuamd_decode.sv */
// cpu instruction decode and effective address forming
//
// Overview of operation
// - inherent: one byte, no operand address
// - immediate: two bytes, data used directly
// - direct: two bytes, high address zero
// - bit branch: three bytes, direct plus displacement
// - extended: three bytes, high then low
// - indexed plain: one byte, index as address
// - indexed byte offset: index plus byte
// - indexed word offset: index plus word
// - taken branch adds signed displacement
// - rmw writes back, except negative-zero test
// - reg/mem: register plus memory operand
// - opcode picks bit and sense; bit to carry
// - bit set/clear use direct page
// - branches relative; jumps take no register
// - control instructions decode as inherent
// - oscillator halt enables interrupt pin wake
// - wait stops clock, clears interrupt mask
// - branches on interrupt pin level exist
// - reg/mem operation set complete
// - rmw operation set complete
`timescale 1ns/100ps
`default_nettype none
`include "cpuamd_defs.svh"

module cpuamd_decode (
    input  wire logic                  sys_clk,
    input  wire logic                  reset_n,
    input  wire logic                  decodeStart,
    input  wire cpuamd_pkg::cpuamd_req_t req,
    input  wire logic                  irqPin,
    output cpuamd_pkg::cpuamd_result_t result,
    output logic                       decodeDone,
    output logic                       stopOsc,
    output logic                       irqPinEnable,
    output logic                       cpuClockStop,
    output logic                       clearIMask
);

    // ----------------------------------------
    // opcode lookup
    // ----------------------------------------
    cpuamd_pkg::cpuamd_info_t info;

    cpuamd_opcode_class u_class (
        .opcode (req.opcode),
        .info   (info)
    );

    // ----------------------------------------
    // interrupt pin synchroniser
    // ----------------------------------------
    logic irqMeta;
    logic irqSync;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irqMeta <= 1'b0;
            irqSync <= 1'b0;
        end else begin
            irqMeta <= irqPin;
            irqSync <= irqMeta;
        end
    end

    // ----------------------------------------
    // branch conditions
    // ----------------------------------------
    // even opcode tests the base sense, odd the inverse
    function automatic logic relCond(input logic [7:0] op,
                                     input cpuamd_pkg::cpuamd_ccr_t f,
                                     input logic pinHigh);
        logic base;
        base = 1'b0;
        unique case (op[3:1])
            3'h0: base = 1'b1;
            3'h1: base = !(f.c || f.z);
            3'h2: base = !f.c;
            3'h3: base = !f.z;
            3'h4: base = !f.h;
            3'h5: base = !f.n;
            3'h6: base = !f.i;
            3'h7: base = !pinHigh;
        endcase
        return base ^ op[0];
    endfunction

    function automatic logic [15:0] signExt(input logic [7:0] d);
        return {{8{d[7]}}, d};
    endfunction

    // ----------------------------------------
    // address forming
    // ----------------------------------------
    logic [15:0] next_effAddr;
    logic        next_addrValid;
    logic [15:0] seqPc;
    logic [7:0]  disp;
    logic        testedBit;
    logic        next_taken;
    logic [15:0] next_pc;
    logic [7:0]  bitDecode;

    // the tested bit number sits in the opcode
    assign testedBit = req.memByte[req.opcode[3:1]];

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_mask
            assign bitDecode[gi] = (req.opcode[3:1] == 3'(gi));
        end
    endgenerate

    always_comb begin
        next_effAddr = `CPUAMD_ADDR_RST;
        next_addrValid = 1'b1;
        unique case (info.mode)
            cpuamd_pkg::CPUAMD_INH,
            cpuamd_pkg::CPUAMD_IMM,
            cpuamd_pkg::CPUAMD_REL: begin
                next_addrValid = 1'b0;
            end
            cpuamd_pkg::CPUAMD_DIR: begin
                next_effAddr = {`CPUAMD_PAGE_ZERO, req.operand1};
            end
            cpuamd_pkg::CPUAMD_EXT: begin
                next_effAddr = {req.operand1, req.operand2};
            end
            cpuamd_pkg::CPUAMD_IX: begin
                next_effAddr = {`CPUAMD_PAGE_ZERO, req.indexReg};
            end
            cpuamd_pkg::CPUAMD_IX1: begin
                next_effAddr = {`CPUAMD_PAGE_ZERO, req.operand1}
                             + {`CPUAMD_PAGE_ZERO, req.indexReg};
            end
            cpuamd_pkg::CPUAMD_IX2: begin
                next_effAddr = {req.operand1, req.operand2}
                             + {`CPUAMD_PAGE_ZERO, req.indexReg};
            end
        endcase
    end

    // ----------------------------------------
    // program flow
    // ----------------------------------------
    // sequential pc first, so a displacement is taken from the next opcode
    assign seqPc = req.pc + {14'h0000, info.length};
    assign disp = (req.opcode[7:4] == `CPUAMD_ROW_BITBR) ? req.operand2 : req.operand1;

    always_comb begin
        next_taken = 1'b0;
        next_pc = seqPc;
        if (info.iclass == cpuamd_pkg::CPUAMD_BITMAN &&
            req.opcode[7:4] == `CPUAMD_ROW_BITBR) begin
            next_taken = (testedBit != req.opcode[0]);
        end else if (info.mode == cpuamd_pkg::CPUAMD_REL) begin
            next_taken = (req.opcode == `CPUAMD_OP_BSR) ||
                         relCond(req.opcode, req.ccr, irqSync);
        end
        if (next_taken) begin
            next_pc = seqPc + signExt(disp);
        end
        if (info.isJump) begin
            next_taken = 1'b1;
            next_pc = next_effAddr;
        end
    end

    // ----------------------------------------
    // result register
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            result <= '0;
        end else if (decodeStart) begin
            result.length <= info.length;
            result.mode <= info.mode;
            result.iclass <= info.iclass;
            result.opSel <= req.opcode[3:0];
            result.effAddr <= next_effAddr;
            result.addrValid <= next_addrValid;
            result.nextPc <= next_pc;
            result.branchTaken <= next_taken;
            // jumps never name a register operand
            result.usesIndex <= info.usesIndex && !info.isJump;
            result.bitMask <= bitDecode;
            result.bitValue <= !req.opcode[0];
            result.writeBack <= (info.iclass == cpuamd_pkg::CPUAMD_RMW && !info.isTest) ||
                (info.iclass == cpuamd_pkg::CPUAMD_BITMAN &&
                 req.opcode[7:4] == `CPUAMD_ROW_BITMAN);
            result.carryLoad <= (req.opcode[7:4] == `CPUAMD_ROW_BITBR);
            result.carryValue <= testedBit;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            decodeDone <= 1'b0;
        end else begin
            decodeDone <= decodeStart;
        end
    end

    // ----------------------------------------
    // low power controls
    // ----------------------------------------
    // pin stays enabled until the next decode, which follows the wake
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stopOsc <= 1'b0;
            irqPinEnable <= 1'b0;
            cpuClockStop <= 1'b0;
            clearIMask <= 1'b0;
        end else begin
            stopOsc <= decodeStart && info.isStop;
            cpuClockStop <= decodeStart && info.isWait;
            clearIMask <= decodeStart && info.isWait;
            if (decodeStart) begin
                irqPinEnable <= info.isStop;
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    a_inherent_len: assert property (
        decodeDone && result.mode == cpuamd_pkg::CPUAMD_INH
        |-> result.length == 2'h1 && !result.addrValid)
        else $error("inherent decode has wrong length or address");

    a_immed_len: assert property (
        decodeDone && result.mode == cpuamd_pkg::CPUAMD_IMM
        |-> result.length == 2'h2 && !result.addrValid)
        else $error("immediate decode has wrong length or address");

    a_direct_addr: assert property (
        decodeStart && info.mode == cpuamd_pkg::CPUAMD_DIR
        |=> result.effAddr == {8'h00, $past(req.operand1)})
        else $error("direct address not in page zero");

    a_bitbr_len: assert property (
        decodeStart && req.opcode[7:4] == 4'h0
        |=> result.length == 2'h3 && result.carryLoad)
        else $error("bit branch length or carry load wrong");

    a_ext_addr: assert property (
        decodeStart && req.opcode[7:4] == 4'hC
        |=> result.length == 2'h3 &&
            result.effAddr == {$past(req.operand1), $past(req.operand2)})
        else $error("extended address wrong");

    a_ix_addr: assert property (
        decodeStart && req.opcode[7:4] == 4'hF
        |=> result.length == 2'h1 && result.effAddr == {8'h00, $past(req.indexReg)})
        else $error("indexed address wrong");

    a_ix1_addr: assert property (
        decodeStart && req.opcode[7:4] == 4'hE
        |=> result.effAddr == 16'($past(req.operand1)) + 16'($past(req.indexReg))
            && result.effAddr <= 16'h01FE)
        else $error("indexed byte offset address wrong");

    a_ix2_addr: assert property (
        decodeStart && req.opcode[7:4] == 4'hD
        |=> result.effAddr == {$past(req.operand1), $past(req.operand2)}
            + 16'($past(req.indexReg)))
        else $error("indexed word offset address wrong");

    a_rel_target: assert property (
        decodeStart && req.opcode[7:4] == 4'h2
        |=> result.nextPc == $past(req.pc) + 16'h0002
            + (result.branchTaken ? {{8{$past(req.operand1[7])}}, $past(req.operand1)} : 16'h0000))
        else $error("relative branch target wrong");

    a_test_nowrite: assert property (
        decodeStart && info.isTest
        |=> !result.writeBack && result.iclass == cpuamd_pkg::CPUAMD_RMW)
        else $error("negative-zero test writes back");

    a_stop_wake: assert property (
        decodeStart && info.isStop
        |=> stopOsc && irqPinEnable)
        else $error("halt did not enable the wake pin");

    a_stop_pulse: assert property (
        decodeStart && info.isStop ##1 !(decodeStart && info.isStop)
        |=> !stopOsc)
        else $error("oscillator halt held past one cycle");

    a_wait_mask: assert property (
        decodeStart && info.isWait
        |=> cpuClockStop && clearIMask && !stopOsc)
        else $error("wait did not stop clock and clear mask");

    c_rel_taken: cover property (
        decodeDone && result.branchTaken && result.mode == cpuamd_pkg::CPUAMD_REL);
    c_bit_branch: cover property (decodeDone && result.carryLoad && result.branchTaken);
    c_stop_seen: cover property (stopOsc ##1 irqPinEnable);
    c_rmw_write: cover property (decodeDone && result.writeBack);

endmodule
`default_nettype wire

/* rtl/cpuamd_opcode_class.sv */
// opcode to addressing mode, class and length lookup
`timescale 1ns/100ps
`default_nettype none
`include "cpuamd_defs.svh"

module cpuamd_opcode_class (
    input  wire logic [7:0]          opcode,
    output cpuamd_pkg::cpuamd_info_t info
);

    logic [3:0] row;
    logic [3:0] low;

    assign row = opcode[7:4];
    assign low = opcode[3:0];

    // rmw rows leave some low codes undefined; multiply sits in one of them
    function automatic logic rmwLegal(input logic [7:0] op);
        return !(op[3:0] inside {4'h1, 4'h2, 4'h5, 4'hB, 4'hE});
    endfunction

    always_comb begin
        info = '0;
        info.length = `CPUAMD_LEN_ONE;
        info.mode = cpuamd_pkg::CPUAMD_INH;
        info.iclass = cpuamd_pkg::CPUAMD_CONTROL;
        unique case (row)
            `CPUAMD_ROW_BITBR: begin
                info.length = `CPUAMD_LEN_THREE;
                info.mode = cpuamd_pkg::CPUAMD_DIR;
                info.iclass = cpuamd_pkg::CPUAMD_BITMAN;
            end
            `CPUAMD_ROW_BITMAN: begin
                info.length = `CPUAMD_LEN_TWO;
                info.mode = cpuamd_pkg::CPUAMD_DIR;
                info.iclass = cpuamd_pkg::CPUAMD_BITMAN;
            end
            `CPUAMD_ROW_REL: begin
                info.length = `CPUAMD_LEN_TWO;
                info.mode = cpuamd_pkg::CPUAMD_REL;
                info.iclass = cpuamd_pkg::CPUAMD_JUMPBR;
            end
            `CPUAMD_ROW_RMWD, `CPUAMD_ROW_RMWA, `CPUAMD_ROW_RMWX,
            `CPUAMD_ROW_RMW1, `CPUAMD_ROW_RMW0: begin
                info.iclass = cpuamd_pkg::CPUAMD_RMW;
                info.isTest = (low == `CPUAMD_LO_NZTEST);
                info.usesIndex = (row == `CPUAMD_ROW_RMWX);
                if (row == `CPUAMD_ROW_RMWD) begin
                    info.length = `CPUAMD_LEN_TWO;
                    info.mode = cpuamd_pkg::CPUAMD_DIR;
                end else if (row == `CPUAMD_ROW_RMW1) begin
                    info.length = `CPUAMD_LEN_TWO;
                    info.mode = cpuamd_pkg::CPUAMD_IX1;
                end else if (row == `CPUAMD_ROW_RMW0) begin
                    info.mode = cpuamd_pkg::CPUAMD_IX;
                end
                if (opcode == `CPUAMD_OP_MULTIPLY) begin
                    info.iclass = cpuamd_pkg::CPUAMD_REGMEM;
                end else if (!rmwLegal(opcode)) begin
                    info.iclass = cpuamd_pkg::CPUAMD_ILLEGAL;
                end
            end
            `CPUAMD_ROW_CTLA, `CPUAMD_ROW_CTLB: begin
                info.isStop = (opcode == `CPUAMD_OP_STOP);
                info.isWait = (opcode == `CPUAMD_OP_WAIT);
            end
            default: begin
                info.iclass = cpuamd_pkg::CPUAMD_REGMEM;
                info.isJump = (low == `CPUAMD_LO_UJUMP) || (low == `CPUAMD_LO_SUBJUMP);
                info.usesIndex = !info.isJump &&
                    (low == `CPUAMD_LO_CPX || low == `CPUAMD_LO_LDX || low == `CPUAMD_LO_STX);
                if (info.isJump) begin
                    info.iclass = cpuamd_pkg::CPUAMD_JUMPBR;
                end
                unique case (row)
                    `CPUAMD_ROW_IMM: begin
                        info.length = `CPUAMD_LEN_TWO;
                        info.mode = cpuamd_pkg::CPUAMD_IMM;
                        if (opcode == `CPUAMD_OP_BSR) begin
                            info.mode = cpuamd_pkg::CPUAMD_REL;
                            info.iclass = cpuamd_pkg::CPUAMD_JUMPBR;
                            info.isJump = 1'b0;
                        end
                    end
                    `CPUAMD_ROW_DIR: begin
                        info.length = `CPUAMD_LEN_TWO;
                        info.mode = cpuamd_pkg::CPUAMD_DIR;
                    end
                    `CPUAMD_ROW_EXT: begin
                        info.length = `CPUAMD_LEN_THREE;
                        info.mode = cpuamd_pkg::CPUAMD_EXT;
                    end
                    `CPUAMD_ROW_IX2: begin
                        info.length = `CPUAMD_LEN_THREE;
                        info.mode = cpuamd_pkg::CPUAMD_IX2;
                    end
                    `CPUAMD_ROW_IX1: begin
                        info.length = `CPUAMD_LEN_TWO;
                        info.mode = cpuamd_pkg::CPUAMD_IX1;
                    end
                    default: begin
                        info.mode = cpuamd_pkg::CPUAMD_IX;
                    end
                endcase
            end
        endcase
    end

endmodule
`default_nettype wire

/* shared/cpuamd_defs.svh */
// constants for the cpu addressing mode decoder
`ifndef CPUAMD_DEFS_SVH
`define CPUAMD_DEFS_SVH

// ----------------------------------------
// instruction lengths in bytes
// ----------------------------------------
`define CPUAMD_LEN_ONE   2'h1
`define CPUAMD_LEN_TWO   2'h2
`define CPUAMD_LEN_THREE 2'h3

// ----------------------------------------
// opcode rows (upper nibble)
// ----------------------------------------
`define CPUAMD_ROW_BITBR 4'h0
`define CPUAMD_ROW_BITMAN 4'h1
`define CPUAMD_ROW_REL   4'h2
`define CPUAMD_ROW_RMWD  4'h3
`define CPUAMD_ROW_RMWA  4'h4
`define CPUAMD_ROW_RMWX  4'h5
`define CPUAMD_ROW_RMW1  4'h6
`define CPUAMD_ROW_RMW0  4'h7
`define CPUAMD_ROW_CTLA  4'h8
`define CPUAMD_ROW_CTLB  4'h9
`define CPUAMD_ROW_IMM   4'hA
`define CPUAMD_ROW_DIR   4'hB
`define CPUAMD_ROW_EXT   4'hC
`define CPUAMD_ROW_IX2   4'hD
`define CPUAMD_ROW_IX1   4'hE
`define CPUAMD_ROW_IX    4'hF

// ----------------------------------------
// opcode low nibbles and whole opcodes
// ----------------------------------------
`define CPUAMD_LO_NZTEST 4'hD
`define CPUAMD_LO_UJUMP  4'hC
`define CPUAMD_LO_SUBJUMP 4'hD
`define CPUAMD_LO_CPX    4'h3
`define CPUAMD_LO_LDX    4'hE
`define CPUAMD_LO_STX    4'hF
`define CPUAMD_OP_STOP   8'h8E
`define CPUAMD_OP_WAIT   8'h8F
`define CPUAMD_OP_MULTIPLY 8'h42
`define CPUAMD_OP_BSR    8'hAD

// ----------------------------------------
// address constants and reset values
// ----------------------------------------
`define CPUAMD_PAGE_ZERO 8'h00
`define CPUAMD_ADDR_RST  16'h0000

`endif

/* shared/cpuamd_pkg.sv */
// types shared by the cpu addressing mode decoder
package cpuamd_pkg;

    typedef enum logic [2:0] {
        CPUAMD_INH = 3'b000,
        CPUAMD_IMM = 3'b001,
        CPUAMD_DIR = 3'b010,
        CPUAMD_EXT = 3'b011,
        CPUAMD_IX  = 3'b100,
        CPUAMD_IX1 = 3'b101,
        CPUAMD_IX2 = 3'b110,
        CPUAMD_REL = 3'b111
    } cpuamd_mode_t;

    typedef enum logic [2:0] {
        CPUAMD_REGMEM  = 3'b000,
        CPUAMD_RMW     = 3'b001,
        CPUAMD_JUMPBR  = 3'b010,
        CPUAMD_BITMAN  = 3'b011,
        CPUAMD_CONTROL = 3'b100,
        CPUAMD_ILLEGAL = 3'b101
    } cpuamd_class_t;

    typedef struct packed {
        logic h;
        logic i;
        logic n;
        logic z;
        logic c;
    } cpuamd_ccr_t;

    typedef struct packed {
        logic [7:0]  opcode;
        logic [7:0]  operand1;
        logic [7:0]  operand2;
        logic [15:0] pc;
        logic [7:0]  indexReg;
        logic [7:0]  memByte;
        cpuamd_ccr_t ccr;
    } cpuamd_req_t;

    typedef struct packed {
        logic [1:0]    length;
        cpuamd_mode_t  mode;
        cpuamd_class_t iclass;
        logic          usesIndex;
        logic          isTest;
        logic          isJump;
        logic          isStop;
        logic          isWait;
    } cpuamd_info_t;

    typedef struct packed {
        logic [1:0]    length;
        cpuamd_mode_t  mode;
        cpuamd_class_t iclass;
        logic [3:0]    opSel;
        logic [15:0]   effAddr;
        logic          addrValid;
        logic [15:0]   nextPc;
        logic          branchTaken;
        logic          writeBack;
        logic          usesIndex;
        logic          carryLoad;
        logic          carryValue;
        logic [7:0]    bitMask;
        logic          bitValue;
    } cpuamd_result_t;

endpackage

/* testbench/cpuamd_mem_model.sv */
// memory model for the lower address page, answering the bit branch operand read
`timescale 1ns/100ps
`default_nettype none

module cpuamd_mem_model (
    input  wire logic [7:0] addr,
    output logic      [7:0] data
);
    // a fixed pattern that differs from address to address, so a wrong address gives a wrong bit
    assign data = addr ^ 8'hA5;
endmodule
`default_nettype wire

/* testbench/tb_cpu_addressing_mode_decode.sv */
// self-checking bench for the instruction decoder
`timescale 1ns/100ps
`default_nettype none

module tb_cpu_addressing_mode_decode;
    logic                       sys_clk = 1'b0;
    logic                       reset_n = 1'b0;
    logic                       decodeStart = 1'b0;
    logic                       irqPin = 1'b0;
    logic [7:0]                 opc = 8'h9D, o1 = 8'h00, o2 = 8'h00, ix = 8'h00, memData;
    logic [15:0]                pcv = 16'h0000;
    logic [4:0]                 flg = 5'h00;
    cpuamd_pkg::cpuamd_req_t    req;
    cpuamd_pkg::cpuamd_result_t r;
    logic                       done, stopOsc, pinEn, clkStop, clrI;
    int                         n_fail = 0, compares = 0;
    logic [7:0]                 ctl [13] = '{8'h80, 8'h81, 8'h83, 8'h97, 8'h98, 8'h99, 8'h9A, 8'h9B, 8'h9C,
                                             8'h9D, 8'h9F, 8'h8E, 8'h8F};

    always #2.5 sys_clk = ~sys_clk;
    assign req = {opc, o1, o2, pcv, ix, memData, flg};

    cpuamd_mem_model cpuamd_mem_model_i (.addr(o1), .data(memData));
    cpuamd_decode cpuamd_decode_i (.sys_clk(sys_clk), .reset_n(reset_n), .decodeStart(decodeStart), .req(req),
        .irqPin(irqPin), .result(r), .decodeDone(done), .stopOsc(stopOsc), .irqPinEnable(pinEn),
        .cpuClockStop(clkStop), .clearIMask(clrI));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // start pulse for one edge, then look at the answer one cycle later
    task automatic dec(input logic [7:0] op, a, b, input logic [15:0] pc, input logic [7:0] x);
        @(negedge sys_clk);
        decodeStart = 1'b1;
        opc = op;
        o1 = a;
        o2 = b;
        pcv = pc;
        ix = x;
        @(negedge sys_clk);
        decodeStart = 1'b0;
        chk("decodeDone", 1, done);
    endtask

    task automatic shape(input logic [1:0] l, input cpuamd_pkg::cpuamd_mode_t m, input cpuamd_pkg::cpuamd_class_t c);
        chk("length", l, r.length);
        chk("mode", m, r.mode);
        chk("iclass", c, r.iclass);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_modes;
        dec(8'h4C, 8'h77, 8'h66, 16'h0300, 8'h00);
        shape(1, cpuamd_pkg::CPUAMD_INH, cpuamd_pkg::CPUAMD_RMW);
        chk("addrValid", 0, r.addrValid);
        chk("nextPc", 16'h0301, r.nextPc);
        dec(8'hA6, 8'h55, 8'h00, 16'h0300, 8'h00);
        shape(2, cpuamd_pkg::CPUAMD_IMM, cpuamd_pkg::CPUAMD_REGMEM);
        chk("addrValid", 0, r.addrValid);
        chk("usesIndex", 0, r.usesIndex);
        dec(8'hAE, 8'h55, 8'h00, 16'h0300, 8'h00);
        chk("usesIndex", 1, r.usesIndex);
        dec(8'hB6, 8'hFF, 8'h12, 16'h0300, 8'h00);
        shape(2, cpuamd_pkg::CPUAMD_DIR, cpuamd_pkg::CPUAMD_REGMEM);
        chk("effAddr", 16'h00FF, r.effAddr);
        dec(8'hC6, 8'h12, 8'h34, 16'h0300, 8'h00);
        shape(3, cpuamd_pkg::CPUAMD_EXT, cpuamd_pkg::CPUAMD_REGMEM);
        chk("effAddr", 16'h1234, r.effAddr);
        dec(8'hF6, 8'h12, 8'h34, 16'h0300, 8'hFF);
        shape(1, cpuamd_pkg::CPUAMD_IX, cpuamd_pkg::CPUAMD_REGMEM);
        chk("effAddr", 16'h00FF, r.effAddr);
        dec(8'hE6, 8'hFF, 8'h34, 16'h0300, 8'hFF);
        shape(2, cpuamd_pkg::CPUAMD_IX1, cpuamd_pkg::CPUAMD_REGMEM);
        chk("effAddr", 16'h01FE, r.effAddr);
        dec(8'hD6, 8'h12, 8'hF0, 16'h0300, 8'h20);
        shape(3, cpuamd_pkg::CPUAMD_IX2, cpuamd_pkg::CPUAMD_REGMEM);
        chk("effAddr", 16'h1310, r.effAddr);
    endtask

    task automatic t_branch;
        dec(8'h20, 8'h80, 8'h00, 16'h0100, 8'h00);
        shape(2, cpuamd_pkg::CPUAMD_REL, cpuamd_pkg::CPUAMD_JUMPBR);
        chk("nextPc", 16'h0082, r.nextPc);
        dec(8'h20, 8'h7F, 8'h00, 16'h0100, 8'h00);
        chk("nextPc", 16'h0181, r.nextPc);
        dec(8'h21, 8'h7F, 8'h00, 16'h0100, 8'h00);
        chk("branchTaken", 0, r.branchTaken);
        chk("nextPc", 16'h0102, r.nextPc);
        // zero flag set: equal branches, higher does not
        flg = 5'h02;
        dec(8'h27, 8'h10, 8'h00, 16'h0100, 8'h00);
        chk("zeroSet", 16'h0112, r.nextPc);
        dec(8'h22, 8'h10, 8'h00, 16'h0100, 8'h00);
        chk("higher", 16'h0102, r.nextPc);
        flg = 5'h00;
        dec(8'hAD, 8'h10, 8'h00, 16'h0100, 8'h00);
        chk("subBranch", 16'h0112, r.nextPc);
        dec(8'hCC, 8'h12, 8'h34, 16'h0100, 8'h00);
        chk("jump", 16'h1234, r.nextPc);
        chk("usesIndex", 0, r.usesIndex);
    endtask

    // pattern at address 0 is 8'hA5: bit 2 set, bit 3 clear
    task automatic t_bits;
        dec(8'h04, 8'h00, 8'h10, 16'h0200, 8'h00);
        shape(3, cpuamd_pkg::CPUAMD_DIR, cpuamd_pkg::CPUAMD_BITMAN);
        chk("nextPc", 16'h0213, r.nextPc);
        chk("carry", 2'b11, {r.carryLoad, r.carryValue});
        dec(8'h05, 8'h00, 8'h10, 16'h0200, 8'h00);
        chk("nextPc", 16'h0203, r.nextPc);
        dec(8'h07, 8'h00, 8'hF0, 16'h0200, 8'h00);
        chk("nextPc", 16'h01F3, r.nextPc);
        chk("carry", 2'b10, {r.carryLoad, r.carryValue});
        dec(8'h1A, 8'h44, 8'h00, 16'h0200, 8'h00);
        shape(2, cpuamd_pkg::CPUAMD_DIR, cpuamd_pkg::CPUAMD_BITMAN);
        chk("bitSet", 16'h0120, {r.bitValue, r.bitMask});
        chk("effAddr", 16'h0044, r.effAddr);
        dec(8'h1B, 8'h44, 8'h00, 16'h0200, 8'h00);
        chk("bitClr", 16'h0020, {r.bitValue, r.bitMask});
    endtask

    task automatic t_sets;
        for (int i = 0; i < 16; i++) begin
            if (16'hB7D9 >> i & 1) begin
                dec(8'h30 | i[7:0], 8'h40, 8'h00, 16'h0100, 8'h00);
                shape(2, cpuamd_pkg::CPUAMD_DIR, cpuamd_pkg::CPUAMD_RMW);
                chk("writeBack", i != 13, r.writeBack);
            end else begin
                dec(8'h30 | i[7:0], 8'h40, 8'h00, 16'h0100, 8'h00);
                chk("illegal", cpuamd_pkg::CPUAMD_ILLEGAL, r.iclass);
            end
            if (i != 12 && i != 13) begin
                dec(8'hB0 | i[7:0], 8'h40, 8'h00, 16'h0100, 8'h00);
                chk("regmem", cpuamd_pkg::CPUAMD_REGMEM, r.iclass);
                chk("opSel", i, r.opSel);
            end
        end
        dec(8'h42, 8'h00, 8'h00, 16'h0100, 8'h00);
        shape(1, cpuamd_pkg::CPUAMD_INH, cpuamd_pkg::CPUAMD_REGMEM);
        foreach (ctl[k]) begin
            dec(ctl[k], 8'h00, 8'h00, 16'h0100, 8'h00);
            shape(1, cpuamd_pkg::CPUAMD_INH, cpuamd_pkg::CPUAMD_CONTROL);
        end
    endtask

    task automatic t_power;
        dec(8'h8E, 8'h00, 8'h00, 16'h0100, 8'h00);
        chk("stop", 2'b11, {stopOsc, pinEn});
        @(negedge sys_clk);
        chk("stop", 2'b01, {stopOsc, pinEn});
        dec(8'h8F, 8'h00, 8'h00, 16'h0100, 8'h00);
        chk("wait", 3'b110, {clkStop, clrI, pinEn});
        @(negedge sys_clk);
        chk("wait", 2'b00, {clkStop, clrI});
    endtask

    // the pin passes two synchroniser flops, so it is given three cycles to settle
    task automatic t_pin;
        irqPin = 1'b1;
        repeat (3) @(negedge sys_clk);
        dec(8'h2F, 8'h08, 8'h00, 16'h0100, 8'h00);
        chk("pinHigh", 16'h010A, r.nextPc);
        dec(8'h2E, 8'h08, 8'h00, 16'h0100, 8'h00);
        chk("pinLow", 16'h0102, r.nextPc);
        irqPin = 1'b0;
        repeat (3) @(negedge sys_clk);
        dec(8'h2E, 8'h08, 8'h00, 16'h0100, 8'h00);
        chk("pinLow", 16'h010A, r.nextPc);
    endtask

    task automatic stop_test;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (20) @(negedge sys_clk);
        reset_n = 1'b1;
        t_modes;
        t_branch;
        t_bits;
        t_sets;
        t_power;
        t_pin;
        stop_test;
    end

    initial begin
        repeat (3000) @(posedge sys_clk);
        n_fail++;
        stop_test;
    end
endmodule
`default_nettype wire
